/* inc/cwm_pkg.sv */
// Operation
// [RQ1] Dwell time is an 8-bit count of 500 ms ticks, reset 0x14.
// [RQ2] Ready timeout is the 8-bit setting times 0.32 ms, reset 0x20.
// [RQ3] With stop-suppress clear, a stop closes the communication window.
// [RQ4] With stop-suppress set, no start within ready timeout aborts the window.
// [RQ5] Read-only write check runs while check-disable is clear, skipped when set.
// [RQ6] Streaming override forces streaming in normal power regardless of event mode.
// [RQ7] Host leaves reserved settings bits four to one cleared.
// [RQ8] Host always writes reserved settings bit zero as one.
// [RQ9] Angle sensor is kept inactive in ultra-low power mode.
// [RQ10] Communication mode select: clear streams every cycle, set is event driven.
// [RQ11] Auto switching disabled keeps the manually selected power mode.
// [RQ12] Auto switching steps one mode lower after idle dwell, activity restarts it.
package cwm_pkg;
	localparam logic [7:0] DWELL_OFFSET = 8'hd6;
	localparam logic [7:0] RDY_OFFSET = 8'hd8;
	localparam logic [7:0] SETTINGS_OFFSET = 8'hd9;
	localparam logic [7:0] DWELL_RESET = 8'h14;
	localparam logic [7:0] RDY_RESET = 8'h20;
	localparam logic [7:0] SETTINGS_RESET = 8'h01;
	localparam int STOP_SUPPRESS_BIT = 7;
	localparam int RO_CHECK_OFF_BIT = 6;
	localparam int NP_STREAM_BIT = 5;
	localparam int CLK_HZ = 25_000_000;
	localparam int DWELL_TICK_MS = 500;
	localparam int RDY_TICK_US = 320;
	localparam int DWELL_TICK_CYCLES = DWELL_TICK_MS * (CLK_HZ / 1000);
	localparam int RDY_TICK_CYCLES = RDY_TICK_US * (CLK_HZ / 1_000_000);
	localparam logic [1:0] MODE_NORMAL_POWER = 2'h0;
	localparam logic [1:0] MODE_LOW_POWER = 2'h1;
	localparam logic [1:0] MODE_ULTRA_LOW_POWER = 2'h2;
	localparam logic [1:0] MODE_HALT = 2'h3;

	typedef struct packed {
		logic stop_suppress;
		logic ro_check_off;
		logic normal_power_stream_force;
		logic [4:0] reserved;
	} cwm_settings_type;

	typedef enum logic [1:0] {WIN_IDLE, WIN_OPEN, WIN_HELD} cwm_win_state_type;
endpackage : cwm_pkg

/* rtl/cwm_comms_mode_timing.sv */
`timescale 1ns/100ps
`default_nettype none
module cwm_comms_mode_timing #(
	parameter int DWELL_TICK_CYCLES = cwm_pkg::DWELL_TICK_CYCLES,
	parameter int RDY_TICK_CYCLES = cwm_pkg::RDY_TICK_CYCLES
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Register port from the serial engine
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// Serial bus conditions
	input wire logic i_start_det,
	input wire logic i_stop_det,
	// Power mode controls from the system settings
	input wire logic i_event_mode,
	input wire logic i_auto_disable,
	input wire logic i_ulp_enable,
	input wire logic [1:0] i_manual_mode,
	input wire logic i_activity,
	// Window status
	output logic o_window_active,
	output logic o_window_close,
	output logic o_window_abort,
	// Device behaviour
	output logic [1:0] o_power_mode,
	output logic o_stream_enable,
	output logic o_angle_sensor_enable,
	output logic o_ro_check_enable
);
	if (DWELL_TICK_CYCLES < 1 || RDY_TICK_CYCLES < 1) begin : g_bad_params
		$error("cwm_comms_mode_timing: tick counts must be at least one.");
	end

	logic [7:0] dwell_r;
	logic [7:0] rdy_r;
	cwm_pkg::cwm_settings_type settings_r;
	logic [7:0] rdata_r;
	cwm_pkg::cwm_win_state_type win_r;
	cwm_pkg::cwm_win_state_type win_nxt;
	logic close_r;
	logic abort_r;
	logic [1:0] mode_r;
	logic [1:0] mode_nxt;

	wire logic wr_dwell = i_reg_wr && (i_reg_addr == cwm_pkg::DWELL_OFFSET);
	wire logic wr_rdy = i_reg_wr && (i_reg_addr == cwm_pkg::RDY_OFFSET);
	wire logic wr_settings = i_reg_wr && (i_reg_addr == cwm_pkg::SETTINGS_OFFSET);
	wire logic [7:0] rdata_nxt = (i_reg_addr == cwm_pkg::DWELL_OFFSET) ? dwell_r :
		(i_reg_addr == cwm_pkg::RDY_OFFSET) ? rdy_r :
		(i_reg_addr == cwm_pkg::SETTINGS_OFFSET) ? settings_r : 8'h00;

	// Register bank with printed reset values.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			dwell_r <= cwm_pkg::DWELL_RESET; // [RQ1]
			rdy_r <= cwm_pkg::RDY_RESET; // [RQ2]
			settings_r <= cwm_pkg::SETTINGS_RESET;
			rdata_r <= 8'h00;
		end else begin
			dwell_r <= wr_dwell ? i_reg_wdata : dwell_r;
			rdy_r <= wr_rdy ? i_reg_wdata : rdy_r;
			settings_r <= wr_settings ? i_reg_wdata : settings_r;
			rdata_r <= rdata_nxt;
		end
	end

	// Ready timeout timer counts 0.32 ms ticks while a stop is being held.
	logic rdy_expired;
	wire logic stop_held = (win_r == cwm_pkg::WIN_OPEN) && i_stop_det && settings_r.stop_suppress;
	wire logic rdy_cancel = (win_r != cwm_pkg::WIN_HELD) && !stop_held;
	cwm_tick_timer #(
		.TICK_CYCLES(RDY_TICK_CYCLES),
		.CNT_W(8)
	) u_rdy_timer (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_load(stop_held), // [RQ2]
		.i_cancel(rdy_cancel),
		.i_ticks(rdy_r),
		.o_running(),
		.o_expired(rdy_expired)
	);

	// Communication window sequencing.
	always_comb begin
		win_nxt = win_r;
		unique case (win_r)
			cwm_pkg::WIN_IDLE: begin
				if (i_start_det) begin
					win_nxt = cwm_pkg::WIN_OPEN;
				end
			end
			cwm_pkg::WIN_OPEN: begin
				if (i_stop_det) begin
					win_nxt = settings_r.stop_suppress ? cwm_pkg::WIN_HELD : cwm_pkg::WIN_IDLE; // [RQ3] [RQ4]
				end
			end
			cwm_pkg::WIN_HELD: begin
				if (i_start_det) begin
					win_nxt = cwm_pkg::WIN_OPEN;
				end else if (rdy_expired) begin
					win_nxt = cwm_pkg::WIN_IDLE; // [RQ4]
				end
			end
			default: begin
				win_nxt = cwm_pkg::WIN_IDLE;
			end
		endcase
	end

	wire logic close_nxt = (win_r == cwm_pkg::WIN_OPEN) && i_stop_det && !settings_r.stop_suppress; // [RQ3]
	wire logic abort_nxt = (win_r == cwm_pkg::WIN_HELD) && !i_start_det && rdy_expired; // [RQ4]

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			win_r <= cwm_pkg::WIN_IDLE;
			close_r <= 1'b0;
			abort_r <= 1'b0;
		end else begin
			win_r <= win_nxt;
			close_r <= close_nxt;
			abort_r <= abort_nxt;
		end
	end

	// Dwell timer counts 500 ms ticks while auto switching is enabled.
	logic dwell_running;
	logic dwell_expired;
	wire logic auto_on = !i_auto_disable;
	wire logic dwell_load = auto_on && (i_activity || (!dwell_running && !dwell_expired)); // [RQ12]
	cwm_tick_timer #(
		.TICK_CYCLES(DWELL_TICK_CYCLES),
		.CNT_W(8)
	) u_dwell_timer (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_load(dwell_load), // [RQ1]
		.i_cancel(!auto_on),
		.i_ticks(dwell_r),
		.o_running(dwell_running),
		.o_expired(dwell_expired)
	);

	wire logic [1:0] mode_step = (mode_r == cwm_pkg::MODE_NORMAL_POWER) ? cwm_pkg::MODE_LOW_POWER :
		(mode_r == cwm_pkg::MODE_LOW_POWER && i_ulp_enable) ? cwm_pkg::MODE_ULTRA_LOW_POWER : mode_r;

	always_comb begin
		mode_nxt = mode_r;
		if (!auto_on) begin
			mode_nxt = i_manual_mode; // [RQ11]
		end else if (i_activity) begin
			mode_nxt = cwm_pkg::MODE_NORMAL_POWER; // [RQ12]
		end else if (dwell_expired) begin
			mode_nxt = mode_step; // [RQ12]
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mode_r <= cwm_pkg::MODE_NORMAL_POWER;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	wire logic in_np = (mode_r == cwm_pkg::MODE_NORMAL_POWER);
	wire logic in_ulp = (mode_r == cwm_pkg::MODE_ULTRA_LOW_POWER);

	assign o_reg_rdata = rdata_r;
	assign o_window_active = (win_r != cwm_pkg::WIN_IDLE);
	assign o_window_close = close_r;
	assign o_window_abort = abort_r;
	assign o_power_mode = mode_r;
	assign o_stream_enable = !i_event_mode || (settings_r.normal_power_stream_force && in_np); // [RQ6] [RQ10]
	assign o_angle_sensor_enable = !in_ulp && (mode_r != cwm_pkg::MODE_HALT); // [RQ9]
	assign o_ro_check_enable = !settings_r.ro_check_off; // [RQ5]

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_stop_held;
		(win_r == cwm_pkg::WIN_OPEN) && i_stop_det && settings_r.stop_suppress ##1 (win_r == cwm_pkg::WIN_HELD);
	endsequence

	sequence s_timeout_seen;
		(win_r == cwm_pkg::WIN_HELD) && rdy_expired && !i_start_det;
	endsequence

	dwell_write_a: assert property (wr_dwell |=> dwell_r == $past(i_reg_wdata)) // [RQ1]
		else $error("Dwell time register did not take the written value.");
	rdy_write_a: assert property (wr_rdy ##1 !i_reg_wr |=> o_reg_rdata == rdy_r || i_reg_addr != cwm_pkg::RDY_OFFSET) // [RQ2]
		else $error("Ready timeout register read back wrong.");
	stop_close_a: assert property ((win_r == cwm_pkg::WIN_OPEN) && i_stop_det && !settings_r.stop_suppress
		|=> !o_window_active && o_window_close) // [RQ3]
		else $error("Stop did not close the window.");
	held_abort_a: assert property (s_stop_held ##[0:300] s_timeout_seen |=> !o_window_active && o_window_abort && !o_window_close) // [RQ4]
		else $error("Held window did not abort on ready timeout.");
	ro_check_a: assert property (wr_settings |=> o_ro_check_enable == !$past(i_reg_wdata[cwm_pkg::RO_CHECK_OFF_BIT])) // [RQ5]
		else $error("Read-only check enable does not follow the settings write.");
	np_stream_a: assert property (settings_r.normal_power_stream_force && o_power_mode == cwm_pkg::MODE_NORMAL_POWER
		|-> o_stream_enable) // [RQ6]
		else $error("Normal power streaming override not honoured.");
	ulp_angle_a: assert property (o_power_mode == cwm_pkg::MODE_ULTRA_LOW_POWER |-> !o_angle_sensor_enable) // [RQ9]
		else $error("Angle sensor active in ultra-low power.");
	stream_mode_a: assert property (!i_event_mode |-> o_stream_enable) // [RQ10]
		else $error("Streaming mode selected but streaming off.");
	manual_mode_a: assert property (i_auto_disable |=> o_power_mode == $past(i_manual_mode)) // [RQ11]
		else $error("Manual power mode not followed.");
	dwell_step_a: assert property (auto_on && dwell_expired && !i_activity && o_power_mode == cwm_pkg::MODE_NORMAL_POWER
		|=> o_power_mode == cwm_pkg::MODE_LOW_POWER) // [RQ12]
		else $error("Dwell expiry did not step down to low power.");
endmodule : cwm_comms_mode_timing
`default_nettype wire

/* rtl/cwm_tick_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module cwm_tick_timer #(
	parameter int TICK_CYCLES = 8000,
	parameter int CNT_W = 8
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Control
	input wire logic i_load,
	input wire logic i_cancel,
	input wire logic [CNT_W-1:0] i_ticks,
	// Status
	output logic o_running,
	output logic o_expired
);
	localparam int PRE_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

	if (TICK_CYCLES < 1 || CNT_W < 1) begin : g_bad_params
		$error("cwm_tick_timer: TICK_CYCLES and CNT_W must be at least one.");
	end

	logic [PRE_W-1:0] pre_r;
	logic [CNT_W-1:0] rem_r;
	logic running_r;
	logic expired_r;
	wire logic at_zero = (rem_r == '0);
	wire logic pre_wrap = (pre_r == PRE_LAST);

	always_ff @(posedge i_clk) begin
		if (i_rst || i_cancel) begin
			running_r <= 1'b0;
			expired_r <= 1'b0;
			pre_r <= '0;
			rem_r <= '0;
		end else if (i_load) begin
			running_r <= 1'b1;
			expired_r <= 1'b0;
			pre_r <= '0;
			rem_r <= i_ticks;
		end else if (running_r && at_zero) begin
			running_r <= 1'b0;
			expired_r <= 1'b1;
		end else begin
			expired_r <= 1'b0;
			if (running_r) begin
				pre_r <= pre_wrap ? '0 : pre_r + 1'b1;
				rem_r <= pre_wrap ? rem_r - 1'b1 : rem_r;
			end
		end
	end

	assign o_running = running_r;
	assign o_expired = expired_r;
endmodule : cwm_tick_timer
`default_nettype wire

/* tb/cwm_comms_mode_timing_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module cwm_comms_mode_timing_tb;
	localparam int DT = 4;
	localparam int RT = 3;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic reg_wr, start_det, stop_det, event_mode, auto_dis, ulp_en, activity;
	logic [7:0] reg_addr, reg_wdata, rdata, d;
	logic [1:0] man_mode;
	logic win_act, win_close, win_abort, stream_en, angle_en, ro_en;
	logic [1:0] pmode;
	int fails = 0;
	int samples_checked = 0;
	int n;
	always #20 i_clk = ~i_clk;
	cwm_host_model host (.i_clk(i_clk), .i_reg_rdata(rdata), .o_reg_wr(reg_wr), .o_reg_addr(reg_addr),
		.o_reg_wdata(reg_wdata), .o_start_det(start_det), .o_stop_det(stop_det));
	cwm_comms_mode_timing #(.DWELL_TICK_CYCLES(DT), .RDY_TICK_CYCLES(RT)) DUT (.i_clk(i_clk), .i_rst(i_rst),
		.i_reg_wr(reg_wr), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata),
		.i_start_det(start_det), .i_stop_det(stop_det), .i_event_mode(event_mode), .i_auto_disable(auto_dis),
		.i_ulp_enable(ulp_en), .i_manual_mode(man_mode), .i_activity(activity), .o_window_active(win_act),
		.o_window_close(win_close), .o_window_abort(win_abort), .o_power_mode(pmode),
		.o_stream_enable(stream_en), .o_angle_sensor_enable(angle_en), .o_ro_check_enable(ro_en));
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wait_for(input int which, input int maxc, output int cnt);
		logic hit;
		cnt = 0;
		hit = 1'b0;
		while (!hit) begin
			@(posedge i_clk);
			#1;
			cnt++;
			hit = (which == 0) ? (win_abort === 1'b1) : (pmode === which[1:0]);
			if (!hit && cnt >= maxc) begin
				fails++;
				$display("FAIL wait %0d expected 1 seen 0", which);
				end_sim();
			end
		end
	endtask : wait_for
	task automatic set_in(input logic ev, input logic ad, input logic [1:0] mm);
		@(posedge i_clk);
		event_mode <= ev;
		auto_dis <= ad;
		man_mode <= mm;
		@(posedge i_clk);
		#1;
	endtask : set_in
	initial begin
		{event_mode, ulp_en, activity} = 3'b000;
		auto_dis = 1'b1;
		man_mode = 2'h0;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		host.rd(cwm_pkg::DWELL_OFFSET, d);
		check("dwell reset", d, 8'h14);
		host.rd(cwm_pkg::RDY_OFFSET, d);
		check("ready reset", d, 8'h20);
		host.rd(cwm_pkg::SETTINGS_OFFSET, d);
		check("settings reset", d, 8'h01);
		host.wr(8'hd7, 8'h5a);
		host.rd(8'hd7, d);
		check("unmapped read", d, 8'h00);
		host.wr(cwm_pkg::DWELL_OFFSET, 8'h02);
		host.wr(cwm_pkg::RDY_OFFSET, 8'h02);
		host.rd(cwm_pkg::DWELL_OFFSET, d);
		check("dwell write", d, 8'h02);
		host.rd(cwm_pkg::RDY_OFFSET, d);
		check("ready write", d, 8'h02);
		$display("test registers done");
		host.cond(1'b0);
		check("open", win_act, 8'h01);
		host.cond(1'b1);
		check("close pulse", win_close, 8'h01);
		check("closed", win_act, 8'h00);
		host.wr(cwm_pkg::SETTINGS_OFFSET, 8'h80);
		host.rd(cwm_pkg::SETTINGS_OFFSET, d);
		check("settings write", d, 8'h81);
		host.cond(1'b0);
		host.cond(1'b1);
		check("held close", win_close, 8'h00);
		check("held active", win_act, 8'h01);
		host.cond(1'b0);
		host.cond(1'b1);
		wait_for(0, 60, n);
		check("abort late", n >= 2 * RT, 8'h01);
		check("abort bound", n <= 2 * RT + 4, 8'h01);
		check("aborted", win_act, 8'h00);
		$display("test window done");
		check("ro check on", ro_en, 8'h01);
		host.wr(cwm_pkg::SETTINGS_OFFSET, 8'h60);
		#1;
		check("ro check off", ro_en, 8'h00);
		check("stream mode", stream_en, 8'h01);
		set_in(1'b1, 1'b1, cwm_pkg::MODE_NORMAL_POWER);
		check("force stream", stream_en, 8'h01);
		set_in(1'b1, 1'b1, cwm_pkg::MODE_LOW_POWER);
		check("lp mode", pmode, 8'h01);
		check("lp no stream", stream_en, 8'h00);
		host.wr(cwm_pkg::SETTINGS_OFFSET, 8'h00);
		set_in(1'b1, 1'b1, cwm_pkg::MODE_NORMAL_POWER);
		check("event mode", stream_en, 8'h00);
		check("np angle", angle_en, 8'h01);
		set_in(1'b0, 1'b1, cwm_pkg::MODE_ULTRA_LOW_POWER);
		check("ulp angle", angle_en, 8'h00);
		set_in(1'b0, 1'b1, cwm_pkg::MODE_HALT);
		check("halt mode", pmode, 8'h03);
		check("halt angle", angle_en, 8'h00);
		$display("test modes done");
		for (int u = 0; u < 2; u++) begin
			@(posedge i_clk);
			ulp_en <= u[0];
			activity <= 1'b1;
			set_in(1'b0, 1'b0, cwm_pkg::MODE_NORMAL_POWER);
			@(posedge i_clk);
			activity <= 1'b0;
			wait_for(1, 60, n);
			check("dwell late", n >= 2 * DT, 8'h01);
			check("dwell bound", n <= 2 * DT + 4, 8'h01);
			if (u == 0) begin
				repeat (6 * DT) @(posedge i_clk);
				#1;
				check("lp hold", pmode, 8'h01);
			end else begin
				wait_for(2, 60, n);
				check("auto ulp angle", angle_en, 8'h00);
			end
			@(posedge i_clk);
			activity <= 1'b1;
			@(posedge i_clk);
			activity <= 1'b0;
			#1;
			check("activity np", pmode, 8'h00);
		end
		$display("test auto done");
		@(posedge i_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		host.rd(cwm_pkg::DWELL_OFFSET, d);
		check("dwell rereset", d, 8'h14);
		host.rd(cwm_pkg::RDY_OFFSET, d);
		check("ready rereset", d, 8'h20);
		check("mode rereset", pmode, 8'h00);
		$display("test reset done");
		end_sim();
	end
endmodule : cwm_comms_mode_timing_tb
`default_nettype wire

/* tb/cwm_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cwm_host_model (
	// Clock
	input wire logic i_clk,
	// Register port and bus conditions
	input wire logic [7:0] i_reg_rdata,
	output logic o_reg_wr,
	output logic [7:0] o_reg_addr,
	output logic [7:0] o_reg_wdata,
	output logic o_start_det,
	output logic o_stop_det
);
	initial begin
		o_reg_wr = 1'b0;
		o_reg_addr = 8'h00;
		o_reg_wdata = 8'h00;
		o_start_det = 1'b0;
		o_stop_det = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = (a == cwm_pkg::SETTINGS_OFFSET) ? {d[7:5], 4'h0, 1'b1} : d;
		@(posedge i_clk);
		o_reg_wr <= 1'b1;
		o_reg_addr <= a;
		o_reg_wdata <= v;
		@(posedge i_clk);
		o_reg_wr <= 1'b0;
		o_reg_wdata <= ~v;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		o_reg_addr <= a;
		@(posedge i_clk);
		#1;
		d = i_reg_rdata;
	endtask : rd
	task automatic cond(input logic is_stop);
		@(posedge i_clk);
		o_start_det <= !is_stop;
		o_stop_det <= is_stop;
		@(posedge i_clk);
		o_start_det <= 1'b0;
		o_stop_det <= 1'b0;
		#1;
	endtask : cond
endmodule : cwm_host_model
`default_nettype wire
